//--- design/mts_task_sequencer.sv
// modem task sequencer: registers, data buffer, transmit framing and task timing
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "mts_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - frame head: six bytes plus FEC byte
// - head sent from byte0 MSB to FEC LSB
// - buffer free and interrupt after data fetched
// - four bytes sent MSB first, uncoded
// - block: 18 bytes, CRC, FEC, interleave, scramble
// - CRC reinitialised after every finished send or receive task
// - single byte sent MSB first
// - scrambler task: continuous output, no status change
// - new task ends scrambler at first bit
// - reset task aborts, sets free, no interrupt
// - output change appears about three bits later
// - idle start: first bit one period later
// - free rises 36/24/20/1 bits after start
// - task lengths 56/32/240/8 bits
// - receive tasks last 56/24/240/8 bits
// - receive free one bit after last bit
// - filter adds two bit periods of delay
// - three-bit task code decode
// - interrupt pin low when flag and enable
// - send task starts when idle, else waits room; receive task starts at once
////////////////////////////////////////////////////////////////////////////////
module mts_task_sequencer #(
  parameter int BIT_DIV = `MTS_BIT_DIV
) (
  input wire logic clock,
  input wire logic rstn,
  input wire mts_pkg::mts_bus_req_t bus_req,
  output logic [7:0] rd_data,
  output logic transmit_output_pin,
  output logic irq_n,
  output logic buffer_free_flag
);
  import mts_pkg::*;

  localparam int NB = `MTS_DBUF_LEN;
  localparam int FB = `MTS_FRAME_BITS;
  localparam int ROWS = NB + 2;
  localparam int FILT = `MTS_FILT_BITS;
  localparam logic [`MTS_ADDR_W-1:0] NB_A = `MTS_ADDR_W'(NB);

  logic bit_stb;
  logic [7:0] mode_r;
  logic [7:0] dbuf_r [NB];
  logic [NB*8-1:0] dbuf_flat;
  mts_state_t state_r;
  mts_state_t state_nxt;
  logic pend_r;
  mts_task_t pend_code_r;
  logic [FB-1:0] frame_r;
  logic blk_r;
  logic [8:0] len_r;
  logic [8:0] idx_r;
  logic [8:0] free_at_r;
  logic [15:0] crc_r;
  logic [8:0] scr_r;
  logic bit_r;
  logic [FILT-1:0] dly_r;
  logic free_r;
  logic irq_r;
  logic [FB-1:0] frame_ld;
  logic [8:0] len_ld;
  logic [8:0] free_ld;
  logic blk_ld;
  logic [8:0] rx_len;
  logic [7:0] stat_word;
  logic [11:0] cw [ROWS];
  logic [FB-1:0] blk_bits;

  ////////////////////////////////////////////////////////////////////////////
  // coding helpers

  // four check bits per byte
  function automatic logic [3:0] fec4(input logic [7:0] b);
    fec4 = {^(b & `MTS_FEC_M3), ^(b & `MTS_FEC_M2), ^(b & `MTS_FEC_M1), ^(b & `MTS_FEC_M0)};
  endfunction

  // crc over the whole buffer, byte 0 msb first
  function automatic logic [15:0] crc_calc(input logic [15:0] seed,
                                           input logic [NB*8-1:0] d);
    logic [15:0] c;
    c = seed;
    for (int k = NB*8-1; k >= 0; k--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? `MTS_CRC_POLY : 16'h0000);
    crc_calc = c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bit strobe

  mts_bit_clock #(
    .BIT_DIV(BIT_DIV)
  ) u_bit_clock (
    .clock(clock),
    .rstn(rstn),
    .bit_stb(bit_stb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register port decode

  wire [`MTS_ADDR_W-1:0] addr = bus_req.addr;
  wire cmd_wr = bus_req.wr && addr == `MTS_OFF_CMD;
  wire mode_wr = bus_req.wr && addr == `MTS_OFF_MODE;
  wire stat_rd = bus_req.rd && addr == `MTS_OFF_STAT;
  wire [2:0] code = bus_req.wdata[2:0];
  wire tx_mode = mode_r[`MTS_MODE_TX];
  wire scr_en = mode_r[`MTS_MODE_SCR];
  wire dbuf_hit = addr >= `MTS_OFF_DBUF && addr < `MTS_OFF_DBUF + NB_A;
  wire [`MTS_ADDR_W-1:0] dbuf_idx = addr - `MTS_OFF_DBUF;

  // task code decode; a mode flip cancels work like the reset task
  wire mode_flip = mode_wr && bus_req.wdata[`MTS_MODE_TX] != tx_mode;
  wire abort = (cmd_wr && code == reset_task) || mode_flip;
  wire tx_frame_cmd = cmd_wr && tx_mode && (code == send_frame_head_task ||
    code == send_data_block_task || code == send_four_bytes_task ||
    code == send_one_byte_task);
  wire tx_scr_cmd = cmd_wr && tx_mode && code == send_scrambler_pattern_task;
  wire rx_cmd = cmd_wr && !tx_mode && code != rx_null_task && code != rx_reset_task;

  ////////////////////////////////////////////////////////////////////////////
  // data buffer, one flop byte per entry

  for (genvar i = 0; i < NB; i++) begin : g_dbuf
    wire hit = bus_req.wr && addr == `MTS_OFF_DBUF + `MTS_ADDR_W'(i);
    always_ff @(posedge clock) begin
      if (!rstn) begin
        dbuf_r[i] <= 8'h00;
      end else if (hit) begin
        dbuf_r[i] <= bus_req.wdata;
      end
    end
    assign dbuf_flat[(NB-i)*8-1 -: 8] = dbuf_r[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // data block coding: crc, fec per byte, column-wise interleave

  wire [15:0] crc_val = crc_calc(crc_r, dbuf_flat);
  wire [ROWS*8-1:0] blk_bytes = {dbuf_flat, crc_val};

  // each row is a byte with its check bits
  for (genvar r = 0; r < ROWS; r++) begin : g_cw
    wire [7:0] b = blk_bytes[(ROWS-r)*8-1 -: 8];
    assign cw[r] = {b, fec4(b)};
  end

  // send column by column so a burst error spreads over many rows
  for (genvar k = 0; k < FB; k++) begin : g_ilv
    assign blk_bits[FB-1-k] = cw[k % ROWS][11 - k / ROWS];
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame load for the pending task, msb-first at the top of the shifter

  always_comb begin
    frame_ld = '0;
    len_ld = `MTS_TX_LEN_ONE;
    free_ld = `MTS_FREE_ONE;
    blk_ld = 1'b0;
    case (pend_code_r)
      send_frame_head_task: begin
        frame_ld[FB-1 -: `MTS_TX_LEN_HEAD] = {dbuf_flat[NB*8-1 -: 48],
          fec4(dbuf_r[4]), fec4(dbuf_r[5])};
        len_ld = `MTS_TX_LEN_HEAD;
        free_ld = `MTS_FREE_HEAD;
      end
      send_four_bytes_task: begin
        frame_ld[FB-1 -: `MTS_TX_LEN_FOUR] = dbuf_flat[NB*8-1 -: 32];
        len_ld = `MTS_TX_LEN_FOUR;
        free_ld = `MTS_FREE_FOUR;
      end
      send_data_block_task: begin
        frame_ld = blk_bits;
        len_ld = `MTS_TX_LEN_BLOCK;
        free_ld = `MTS_FREE_BLOCK;
        blk_ld = 1'b1;
      end
      send_one_byte_task: begin
        frame_ld[FB-1 -: `MTS_TX_LEN_ONE] = dbuf_r[0];
      end
      default: begin
        frame_ld = '0;
      end
    endcase
  end

  // receive task lengths
  always_comb begin
    case (code)
      seek_frame_head_task: rx_len = `MTS_RX_LEN_SEEK;
      read_head_three_bytes_task: rx_len = `MTS_RX_LEN_HEAD3;
      read_block_task: rx_len = `MTS_RX_LEN_BLOCK;
      read_one_byte_task: rx_len = `MTS_RX_LEN_ONE;
      default: rx_len = `MTS_RX_LEN_OTHER;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing events, all qualified by the bit strobe

  wire last_bit = idx_r == len_r - 9'h001;
  wire sent_last = bit_stb && state_r == st_send && last_bit;
  // a pending task takes over only once the shifter has room
  wire start = bit_stb && pend_r && (state_r == st_idle ||
    state_r == st_scram || sent_last);
  wire start_scr = pend_code_r == send_scrambler_pattern_task;
  mts_state_t start_state;
  assign start_state = start_scr ? st_scram : st_send;
  wire tx_free_set = bit_stb && state_r == st_send &&
    idx_r + 9'h001 == free_at_r;
  wire rx_done = bit_stb && state_r == st_recv && idx_r + 9'h001 == len_r;
  wire free_set = tx_free_set || rx_done;
  wire task_done = sent_last || rx_done;
  wire scr_run = state_r == st_scram || (state_r == st_send && blk_r && scr_en);

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      st_idle, st_scram: if (start) state_nxt = start_state;
      st_send: if (sent_last) state_nxt = start ? start_state : st_idle;
      st_recv: if (rx_done) state_nxt = st_idle;
      default: state_nxt = st_idle;
    endcase
    if (rx_cmd) state_nxt = st_recv;
    if (abort) state_nxt = st_idle;
  end

  always_ff @(posedge clock) begin
    if (!rstn) state_r <= st_idle;
    else state_r <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending task slot; a new write wins over a start in the same cycle

  always_ff @(posedge clock) begin
    if (!rstn || abort) begin
      pend_r <= 1'b0;
      pend_code_r <= null_task;
    end else if (tx_frame_cmd || tx_scr_cmd) begin
      pend_r <= 1'b1;
      pend_code_r <= mts_task_t'(code);
    end else if (start) begin
      pend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shifter and bit counters

  always_ff @(posedge clock) begin
    if (!rstn || abort) begin
      frame_r <= '0;
      blk_r <= 1'b0;
      len_r <= '0;
      idx_r <= '0;
      free_at_r <= '0;
    end else if (rx_cmd) begin
      idx_r <= '0;
      len_r <= rx_len + `MTS_RX_FREE_DLY;
    end else if (start) begin
      frame_r <= frame_ld;
      blk_r <= blk_ld;
      len_r <= len_ld;
      free_at_r <= free_ld;
      idx_r <= '0;
    end else if (bit_stb && (state_r == st_send || state_r == st_recv)) begin
      frame_r <= {frame_r[FB-2:0], 1'b0};
      idx_r <= idx_r + 9'h001;
    end
  end

  // crc start value, back to init after every finished task
  always_ff @(posedge clock) begin
    if (!rstn || abort || task_done) crc_r <= `MTS_CRC_INIT;
  end

  // scrambler: runs only for blocks and pattern task, else held at seed
  always_ff @(posedge clock) begin
    if (!rstn || !scr_run) begin
      scr_r <= `MTS_SCR_SEED;
    end else if (bit_stb) begin
      scr_r <= {scr_r[0] ^ scr_r[4], scr_r[8:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit output through the filter delay line

  always_ff @(posedge clock) begin
    if (!rstn || abort) begin
      bit_r <= 1'b0;
      dly_r <= '0;
    end else if (bit_stb) begin
      case (state_r)
        st_send: bit_r <= frame_r[FB-1] ^ (blk_r & scr_en & scr_r[0]);
        st_scram: bit_r <= scr_r[0];
        default: bit_r <= 1'b0;
      endcase
      dly_r <= {dly_r[FILT-2:0], bit_r};
    end
  end

  // powersave parks the pin low; inversion acts at once
  always_ff @(posedge clock) begin
    if (!rstn) begin
      transmit_output_pin <= 1'b0;
    end else begin
      transmit_output_pin <= !mode_r[`MTS_MODE_PSAVE] &&
        (dly_r[FILT-1] ^ mode_r[`MTS_MODE_INV]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode, status flags and interrupt pin

  always_ff @(posedge clock) begin
    if (!rstn) mode_r <= `MTS_MODE_RST;
    else if (mode_wr) mode_r <= bus_req.wdata;
  end

  // hardware set wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      free_r <= 1'b1;
      irq_r <= 1'b0;
    end else begin
      if (abort || free_set) free_r <= 1'b1;
      else if (tx_frame_cmd || rx_cmd) free_r <= 1'b0;
      if (free_set) irq_r <= 1'b1;
      else if (stat_rd) irq_r <= 1'b0;
    end
  end

  // pin only follows the flag while enabled
  always_ff @(posedge clock) begin
    if (!rstn) begin
      irq_n <= 1'b1;
      buffer_free_flag <= 1'b1;
    end else begin
      irq_n <= !(irq_r && mode_r[`MTS_MODE_IE]);
      buffer_free_flag <= free_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read side: data one cycle after the strobe, zero otherwise

  always_comb begin
    stat_word = 8'h00;
    stat_word[`MTS_STAT_IRQ] = irq_r;
    stat_word[`MTS_STAT_FREE] = free_r;
    stat_word[`MTS_STAT_STATE +: 4] = state_r;
  end

  wire [7:0] rd_mux = (addr == `MTS_OFF_MODE) ? mode_r :
                      (addr == `MTS_OFF_STAT) ? stat_word :
                      dbuf_hit ? dbuf_r[dbuf_idx[4:0]] : 8'h00;

  always_ff @(posedge clock) begin
    if (!rstn) rd_data <= 8'h00;
    else rd_data <= bus_req.rd ? rd_mux : 8'h00;
  end
endmodule // mts_task_sequencer

//--- pkg/mts_consts.svh
// constants of the modem task sequencer: register map, fields, codes and timing
`ifndef MTS_CONSTS_SVH
`define MTS_CONSTS_SVH

// register map, byte offsets on the plain register port
`define MTS_ADDR_W 6
`define MTS_OFF_CMD 6'h00
`define MTS_OFF_MODE 6'h01
`define MTS_OFF_STAT 6'h02
`define MTS_OFF_DBUF 6'h10
`define MTS_DBUF_LEN 18

// mode register fields and reset value
`define MTS_MODE_IE 7
`define MTS_MODE_INV 6
`define MTS_MODE_TX 5
`define MTS_MODE_SCR 4
`define MTS_MODE_PSAVE 3
`define MTS_MODE_RST 8'h00

// status register fields
`define MTS_STAT_IRQ 7
`define MTS_STAT_FREE 6
`define MTS_STAT_STATE 0

// transmit lengths and buffer-free points, in bit periods (56/32/240/8, 36/24/20/1)
`define MTS_FRAME_BITS 240
`define MTS_TX_LEN_HEAD 9'h038
`define MTS_TX_LEN_FOUR 9'h020
`define MTS_TX_LEN_BLOCK 9'h0F0
`define MTS_TX_LEN_ONE 9'h008
`define MTS_FREE_HEAD 9'h024
`define MTS_FREE_FOUR 9'h018
`define MTS_FREE_BLOCK 9'h014
`define MTS_FREE_ONE 9'h001

// receive lengths in bit periods (56/24/240/8, others 16), free delay 1 bit
`define MTS_RX_LEN_SEEK 9'h038
`define MTS_RX_LEN_HEAD3 9'h018
`define MTS_RX_LEN_BLOCK 9'h0F0
`define MTS_RX_LEN_ONE 9'h008
`define MTS_RX_LEN_OTHER 9'h010
`define MTS_RX_FREE_DLY 9'h001

// output filter delay in bit periods
`define MTS_FILT_BITS 2

// bit period: clock 4 ns, bit time 52083 ns (19200 bit/s)
`define MTS_CLK_NS 4
`define MTS_BIT_NS 52083
`define MTS_BIT_DIV (`MTS_BIT_NS / `MTS_CLK_NS)

// coding: crc polynomial and start value, scrambler seed, fec masks
`define MTS_CRC_POLY 16'h1021
`define MTS_CRC_INIT 16'hFFFF
`define MTS_SCR_SEED 9'h1FF
`define MTS_FEC_M0 8'hD5
`define MTS_FEC_M1 8'hB3
`define MTS_FEC_M2 8'h8F
`define MTS_FEC_M3 8'h7C

`endif

//--- pkg/mts_pkg.sv
// types of the modem task sequencer
`include "mts_consts.svh"
package mts_pkg;
  // transmit mode task codes
  typedef enum logic [2:0] {
    null_task = 3'h0, send_frame_head_task = 3'h1, reserved_task = 3'h2,
    send_data_block_task = 3'h3, send_four_bytes_task = 3'h4,
    send_one_byte_task = 3'h5, send_scrambler_pattern_task = 3'h6, reset_task = 3'h7
  } mts_task_t;
  // receive mode task codes
  typedef enum logic [2:0] {
    rx_null_task = 3'h0, seek_frame_head_task = 3'h1, read_head_three_bytes_task = 3'h2,
    read_block_task = 3'h3, seek_frame_sync_task = 3'h4, read_one_byte_task = 3'h5,
    load_sync_bytes_task = 3'h6, rx_reset_task = 3'h7
  } mts_rx_task_t;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    st_idle = 4'h1, st_send = 4'h2, st_scram = 4'h4, st_recv = 4'h8
  } mts_state_t;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`MTS_ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } mts_bus_req_t;
endpackage

//--- design/mts_bit_clock.sv
// bit-period strobe generator for the modem task sequencer
`timescale 1ns/100ps
`include "mts_consts.svh"
module mts_bit_clock #(
  parameter int BIT_DIV = `MTS_BIT_DIV
) (
  input wire logic clock,
  input wire logic rstn,
  output logic bit_stb
);
  localparam int CW = $clog2(BIT_DIV);
  localparam logic [CW-1:0] LAST = CW'(BIT_DIV - 1);

  logic [CW-1:0] cnt_r;
  wire wrap = cnt_r == LAST;

  // free-running divider, one strobe per bit period
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_r <= '0;
      bit_stb <= 1'b0;
    end else begin
      cnt_r <= wrap ? '0 : cnt_r + 1'b1;
      bit_stb <= wrap;
    end
  end
endmodule // mts_bit_clock

//--- sim/mts_seq_checker.sv
// port checker for the modem task sequencer
`timescale 1ns/100ps
`include "mts_consts.svh"
module mts_seq_checker import mts_pkg::*; #(
  parameter int BIT_DIV = `MTS_BIT_DIV
) (
  input wire logic clock,
  input wire logic rstn,
  input wire mts_pkg::mts_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire logic transmit_output_pin,
  input wire logic irq_n,
  input wire logic buffer_free_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic tx_r;
  logic cmd_wr;
  logic st_rd;
  logic [2:0] code;
  ////////////////////////////////////////////////////////////////////////////////
  // command and status decode; codes mean different things per mode
  assign cmd_wr = bus_req.wr && bus_req.addr == `MTS_OFF_CMD;
  assign st_rd = bus_req.rd && bus_req.addr == `MTS_OFF_STAT;
  assign code = bus_req.wdata[2:0];
  // transmit mode follows the mode register writes seen on the port
  always_ff @(posedge clock) begin
    if (!rstn) tx_r <= 1'b0;
    else if (bus_req.wr && bus_req.addr == `MTS_OFF_MODE) tx_r <= bus_req.wdata[`MTS_MODE_TX];
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_task_clears_free: assert property (
    cmd_wr && tx_r && code inside {3'h1, 3'h3, 3'h4, 3'h5} |-> ##2 !buffer_free_flag)
    else $error("data task left buffer free high");
  a_reset_sets_free: assert property (
    cmd_wr && code == 3'h7 |-> ##[1:3] buffer_free_flag)
    else $error("reset task did not set buffer free");
  a_reset_keeps_irq: assert property (
    cmd_wr && code == 3'h7 && irq_n |=> irq_n [*3])
    else $error("reset task raised interrupt");
  a_scram_no_status: assert property (
    cmd_wr && tx_r && code == 3'h6 && buffer_free_flag && irq_n
    |=> (buffer_free_flag && irq_n) [*4])
    else $error("scrambler task changed status");
  a_irq_read_clear: assert property (
    st_rd && !irq_n |-> ##[1:3] irq_n)
    else $error("status read did not release interrupt");
  a_irq_with_free: assert property (
    $fell(irq_n) |-> ##[0:1] buffer_free_flag)
    else $error("interrupt without buffer free");
  // with any divider of four or more a serial bit holds at least four clocks
  a_pin_bit_period: assert property (
    $changed(transmit_output_pin) |=> $stable(transmit_output_pin) [*3])
    else $error("serial output changed inside a bit period");
  a_code_ignored: assert property (
    cmd_wr && tx_r && code inside {3'h0, 3'h2} && buffer_free_flag |=> buffer_free_flag [*4])
    else $error("null or reserved code changed buffer free");
  c_one_byte: cover property (cmd_wr && tx_r && code == 3'h5);
  c_scram: cover property (cmd_wr && tx_r && code == 3'h6);
  c_irq: cover property ($fell(irq_n));
endmodule // mts_seq_checker

bind mts_task_sequencer mts_seq_checker #(.BIT_DIV(BIT_DIV)) chk_u (
  .clock(clock),
  .rstn(rstn),
  .bus_req(bus_req),
  .rd_data(rd_data),
  .transmit_output_pin(transmit_output_pin),
  .irq_n(irq_n),
  .buffer_free_flag(buffer_free_flag)
);

//--- sim/mts_host_model.sv
// host model: register port cycles and task pacing
`timescale 1ns/100ps
`include "mts_consts.svh"
module mts_host_model import mts_pkg::*; #(
  parameter int BIT_DIV = 4
) (
  input wire logic clock,
  input wire logic [7:0] rd_data,
  output mts_pkg::mts_bus_req_t bus_req
);
  initial bus_req = '0;
  // one-cycle write strobe, request held up to the taking edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask
  // buffer bytes go in before the command that uses them
  task automatic load(input logic [7:0] b[$]);
    foreach (b[i]) wr(`MTS_OFF_DBUF + 6'(i), b[i]);
  endtask
  // settle wait after mode change or reset, counted in bit periods
  task automatic bits(input int n);
    repeat (n * BIT_DIV) @(posedge clock);
  endtask
endmodule // mts_host_model

//--- sim/testbench.sv
// self-checking bench for the modem task sequencer
`timescale 1ns/100ps
`include "mts_consts.svh"
module testbench;
  import mts_pkg::*;
  localparam int BD = 4;
  logic clock;
  logic rstn;
  mts_bus_req_t bus_req;
  logic [7:0] rd_data;
  logic transmit_output_pin;
  logic irq_n;
  logic buffer_free_flag;
  logic [63:0] v;
  logic [7:0] d;
  int fails;
  int tests_run;
  int fi;
  ////////////////////////////////////////////////////////////////////////////////
  mts_task_sequencer #(.BIT_DIV(BD)) dut_u (
    .clock(clock),
    .rstn(rstn),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .transmit_output_pin(transmit_output_pin),
    .irq_n(irq_n),
    .buffer_free_flag(buffer_free_flag)
  );
  mts_host_model #(.BIT_DIV(BD)) host_u (
    .clock(clock),
    .rd_data(rd_data),
    .bus_req(bus_req)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // sample mid-bit after the first high bit; first bit of each task is a one
  task automatic grab(input int n);
    int k;
    v = '0;
    fi = -1;
    k = 0;
    while (transmit_output_pin !== 1'b1 && k < 60 * BD) begin
      @(posedge clock);
      k++;
    end
    chk(k <= 5 * BD, 1);
    repeat (BD / 2) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      v = {v[62:0], transmit_output_pin};
      if (fi < 0 && buffer_free_flag === 1'b1) fi = i;
      repeat (BD) @(posedge clock);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    host_u.rd(`MTS_OFF_MODE, d);
    chk(d, `MTS_MODE_RST);
    host_u.wr(`MTS_OFF_MODE, 8'hA0);
    host_u.rd(`MTS_OFF_MODE, d);
    chk(d, 8'hA0);
    host_u.rd(6'h3F, d);
    chk(d, 8'h00);
    host_u.bits(2);
  endtask
  task automatic t_codes;
    host_u.wr(`MTS_OFF_CMD, 8'h00);
    host_u.wr(`MTS_OFF_CMD, 8'h02);
    host_u.bits(4);
    host_u.rd(`MTS_OFF_STAT, d);
    chk(d[6:0], 7'h41);
  endtask
  task automatic t_one;
    host_u.load('{8'hB5});
    host_u.wr(`MTS_OFF_CMD, 8'h05);
    grab(8);
    chk(v[7:0], 8'hB5);
    chk(fi, 0);
    chk(irq_n, 1'b0);
    host_u.rd(`MTS_OFF_STAT, d);
    chk(d[7:6], 2'b11);
    repeat (3) @(posedge clock);
    chk(irq_n, 1'b1);
    host_u.bits(6);
  endtask
  task automatic t_four;
    host_u.load('{8'hDE, 8'hAD, 8'hBE, 8'hEF});
    host_u.wr(`MTS_OFF_CMD, 8'h04);
    grab(32);
    chk(v[31:0], 32'hDEADBEEF);
    chk(fi >= 20 && fi <= 24, 1);
    host_u.rd(`MTS_OFF_STAT, d);
    chk(d[7:6], 2'b11);
    host_u.bits(6);
  endtask
  // fec byte expected from the check masks: 0x12 gives D, 0x34 gives C
  task automatic t_head;
    host_u.load('{8'hAA, 8'hAA, 8'h3C, 8'h5A, 8'h12, 8'h34});
    host_u.wr(`MTS_OFF_CMD, 8'h01);
    grab(56);
    chk(v[55:8], 48'hAAAA3C5A1234);
    chk(v[7:0], 8'hDC);
    chk(fi >= 32 && fi <= 36, 1);
    host_u.rd(`MTS_OFF_STAT, d);
    chk(d[7:6], 2'b11);
    host_u.bits(6);
  endtask
  task automatic t_scram;
    int n;
    n = 0;
    host_u.wr(`MTS_OFF_MODE, 8'hB0);
    host_u.wr(`MTS_OFF_CMD, 8'h06);
    host_u.bits(4);
    d[0] = transmit_output_pin;
    repeat (40) begin
      host_u.bits(1);
      if (transmit_output_pin !== d[0]) n++;
      d[0] = transmit_output_pin;
    end
    chk(n > 4, 1);
    chk({buffer_free_flag, irq_n}, 2'b11);
    host_u.load('{8'h00});
    host_u.wr(`MTS_OFF_CMD, 8'h05);
    repeat (3) @(posedge clock);
    chk(buffer_free_flag, 1'b0);
    host_u.bits(14);
    chk(transmit_output_pin, 1'b0);
    host_u.rd(`MTS_OFF_STAT, d);
    chk(d[7:6], 2'b11);
  endtask
  task automatic t_abort;
    host_u.load('{8'hFF, 8'hFF, 8'hFF, 8'hFF});
    host_u.wr(`MTS_OFF_CMD, 8'h04);
    host_u.bits(8);
    host_u.wr(`MTS_OFF_CMD, 8'h07);
    repeat (3) @(posedge clock);
    chk({buffer_free_flag, irq_n}, 2'b11);
    host_u.bits(5);
    chk(transmit_output_pin, 1'b0);
  endtask
  // receive one byte: free low over nine strobes, then free and irq together
  task automatic t_recv;
    host_u.wr(`MTS_OFF_MODE, 8'h80);
    host_u.bits(2);
    host_u.wr(`MTS_OFF_CMD, 8'h05);
    host_u.bits(7);
    chk(buffer_free_flag, 1'b0);
    host_u.bits(3);
    chk({buffer_free_flag, irq_n}, 2'b10);
    host_u.rd(`MTS_OFF_STAT, d);
    chk(d, 8'hC1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // clock at 250 MHz
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // watchdog well past the expected thousand or so cycles
  initial begin
    #60000;
    fails++;
    close_out();
  end
  // main sequence: reset then scenarios
  initial begin
    fails = 0;
    tests_run = 0;
    rstn = 1'b0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    t_regs();
    t_codes();
    t_one();
    t_four();
    t_head();
    t_scram();
    t_abort();
    t_recv();
    close_out();
  end
endmodule // testbench
